//--- acq_pkg.sv
// constants, register map and state encoding of the acquisition sequencer
package acq_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int MIN_RATE_HZ = 1;
	localparam int CONT_MAX_HZ = 30000;
	localparam int NS_MAX_HZ = 200000;
	localparam logic [31:0] CONT_MIN_PER = 32'((CLK_HZ + CONT_MAX_HZ - 1) / CONT_MAX_HZ);
	localparam logic [31:0] NS_MIN_PER = 32'((CLK_HZ + NS_MAX_HZ - 1) / NS_MAX_HZ);
	localparam logic [31:0] MAX_PER_DEF = 32'(CLK_HZ / MIN_RATE_HZ);
	localparam logic [31:0] MAX_COUNT = 32'h01c9_c380;
	localparam int AW = 25;
	localparam logic [31:0] PKT_WORDS = 32'h0000_0200;
	localparam int NCH = 8;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h04;
	localparam logic [7:0] REG_PERIOD = 8'h08;
	localparam logic [7:0] REG_COUNT = 8'h0c;
	localparam logic [7:0] REG_DELAY = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_RECORDS = 8'h18;
	localparam logic [7:0] REG_RD_INDEX = 8'h1c;
	localparam logic [7:0] REG_RD_DATA = 8'h20;

	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_CLAIM = 2;
	localparam int CTRL_RELEASE = 3;
	localparam int CTRL_ID_LSB = 8;

	localparam int CFG_MASK_LSB = 0;
	localparam int CFG_NSAMPLE = 8;
	localparam int CFG_TRIG_LSB = 12;
	localparam int CFG_CNT_SEL = 16;
	localparam logic [31:0] CFG_WMASK = 32'h0001_71ff;

	localparam logic [2:0] TRG_SW = 3'h0;
	localparam logic [2:0] TRG_EXTCLK = 3'h1;
	localparam logic [2:0] TRG_PRE = 3'h2;
	localparam logic [2:0] TRG_POST = 3'h3;
	localparam logic [2:0] TRG_DELAY = 3'h4;

	localparam int STS_REFUSED = 5;
	localparam int STS_CFG_ERR = 6;
	localparam int STS_OVERRUN = 7;
	localparam int STS_OWNED = 8;
	localparam int STS_RD_VALID = 9;
	localparam int STS_WRAPPED = 10;
	localparam int STS_OWNER_LSB = 16;

	localparam logic [31:0] CFG_RST = 32'h0000_00ff;
	localparam logic [31:0] PERIOD_RST = 32'h0000_9c40;
	localparam logic [31:0] COUNT_RST = 32'h0000_03e8;
	localparam logic [31:0] DELAY_RST = 32'h0000_0000;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARMED = 5'h02,
		ST_DELAY = 5'h04,
		ST_RUN = 5'h08,
		ST_DONE = 5'h10
	} state_t;
endpackage : acq_pkg

//--- edge_if.sv
// pin and edge strobes between the top and a synchroniser
`timescale 1ns/100ps
`default_nettype none
interface edge_if;
	logic pin;
	logic fall;
	logic rise;
	modport det (input pin, output fall, output rise);
	modport user (output pin, input fall, input rise);
endinterface : edge_if
`default_nettype wire

//--- edge_sync.sv
// two-flop synchroniser with edge strobes for one asynchronous pin
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	edge_if.det e
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// only s2_r and s3_r feed the edge logic; s1_r may be metastable
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
		end else begin
			s1_r <= e.pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign e.fall = s3_r && !s2_r;
	assign e.rise = !s3_r && s2_r;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_pin_fell;
		e.pin ##1 !e.pin ##1 !e.pin;
	endsequence
	property p_fall_det;
		s_pin_fell |-> ##1 e.fall;
	endproperty
	a_fall_det: assert property (p_fall_det) else $error("falling edge not flagged");
	property p_rise_det;
		(!e.pin ##1 e.pin ##1 e.pin) |-> ##1 (e.rise && !e.fall);
	endproperty
	a_rise_det: assert property (p_rise_det) else $error("rising edge not flagged");
endmodule : edge_sync
`default_nettype wire

//--- adc_acquisition_sequencer.sv
// acquisition sequencer: ahb-lite registers, pacing, triggers, scan and sample storage
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module adc_acquisition_sequencer #(
	parameter logic [31:0] MAX_PERIOD = acq_pkg::MAX_PER_DEF
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire logic i_ext_trig,
	input wire logic i_ext_clk,
	output logic o_conv_start,
	output logic [2:0] o_conv_chan,
	input wire logic i_conv_done,
	input wire logic [15:0] i_conv_data,
	output logic o_mem_we,
	output logic [24:0] o_mem_addr,
	output logic [31:0] o_mem_wdata,
	output logic o_mem_re,
	output logic [24:0] o_mem_raddr,
	input wire logic [31:0] i_mem_rdata,
	output logic o_pkt_ready,
	output logic o_pkt_bank
);
	acq_pkg::state_t state_r;
	logic [31:0] cfg_r, period_r, count_r, delay_r, dly_cnt_r, div_cnt_r;
	logic [31:0] rec_cnt_r, rd_idx_r, rd_data_r;
	logic [24:0] wr_ptr_r;
	logic [7:0] owner_r, wr_addr_r, mask, cmd_id;
	logic [2:0] trig;
	logic [3:0] first_ch, nxt_ch;
	logic owned_r, wr_pend_r, conv_busy_r, wrapped_r, rd_pend_r, rd_valid_r;
	logic refused_r, cfg_err_r, overrun_r;
	logic nmode, cnt_sel, is_sw, is_ext, is_pre, is_post, is_dly;
	logic st_idle, st_armed, st_dly, st_run, st_done, idle_like;
	logic wr_ctrl, wr_cfg, wr_rdidx, wr_status, owner_ok;
	logic start_req, stop_req, start_ok, start_bad, stop_ok, refuse, combo_ok;
	logic trig_fall, clk_rise, tick, wr_evt, last_rec, pre_hit, halt, rd_ok;
	logic [31:0] period_eff, min_per, count_eff, ptr_inc, ring_top, rec_avail;
	logic [31:0] rd_sum, rd_addr, status_w;

	edge_if trig_if ();
	edge_if eclk_if ();
	assign trig_if.pin = i_ext_trig;
	assign eclk_if.pin = i_ext_clk;
	edge_sync u_trig_sync (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.e(trig_if.det)
	);
	edge_sync u_eclk_sync (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.e(eclk_if.det)
	);
	assign trig_fall = trig_if.fall;
	assign clk_rise = eclk_if.rise;

	function automatic logic [3:0] next_ch(input logic [7:0] m, input logic [3:0] from);
		logic [3:0] r;
		r = 4'h8;
		for (int i = acq_pkg::NCH - 1; i >= 0; i--) begin
			if (m[i] && (4'(i) >= from)) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : next_ch

	assign mask = cfg_r[acq_pkg::CFG_MASK_LSB +: 8];
	assign nmode = cfg_r[acq_pkg::CFG_NSAMPLE];
	assign trig = cfg_r[acq_pkg::CFG_TRIG_LSB +: 3];
	assign cnt_sel = cfg_r[acq_pkg::CFG_CNT_SEL];
	assign is_sw = (trig == acq_pkg::TRG_SW);
	assign is_ext = (trig == acq_pkg::TRG_EXTCLK);
	assign is_pre = (trig == acq_pkg::TRG_PRE);
	assign is_post = (trig == acq_pkg::TRG_POST);
	assign is_dly = (trig == acq_pkg::TRG_DELAY);
	assign st_idle = (state_r == acq_pkg::ST_IDLE);
	assign st_armed = (state_r == acq_pkg::ST_ARMED);
	assign st_dly = (state_r == acq_pkg::ST_DELAY);
	assign st_run = (state_r == acq_pkg::ST_RUN);
	assign st_done = (state_r == acq_pkg::ST_DONE);
	assign idle_like = st_idle || st_done;

	// ext clock only in continuous, pre/post/delay only in n-sample, counter input only with software trigger
	assign combo_ok = (is_sw || (is_ext && !nmode) || ((is_pre || is_post || is_dly) && nmode))
		&& !(cnt_sel && !is_sw) && (mask != 8'h00);

	// bus slave: zero wait states, writes land in the data phase
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
			if (i_hsel && i_htrans[1] && i_hready) begin
				wr_addr_r <= i_haddr[7:0];
			end
		end
	end
	assign wr_ctrl = wr_pend_r && (wr_addr_r == acq_pkg::REG_CTRL);
	assign wr_cfg = wr_pend_r && idle_like;
	assign wr_rdidx = wr_pend_r && (wr_addr_r == acq_pkg::REG_RD_INDEX);
	assign wr_status = wr_pend_r && (wr_addr_r == acq_pkg::REG_STATUS);

	assign cmd_id = i_hwdata[acq_pkg::CTRL_ID_LSB +: 8];
	assign owner_ok = owned_r && (owner_r == cmd_id);
	assign start_req = wr_ctrl && i_hwdata[acq_pkg::CTRL_START];
	assign stop_req = wr_ctrl && i_hwdata[acq_pkg::CTRL_STOP];
	assign stop_ok = stop_req && owner_ok;
	assign start_ok = start_req && owner_ok && idle_like && combo_ok && !stop_req;
	assign start_bad = start_req && owner_ok && idle_like && !combo_ok && !stop_req;
	assign refuse = (wr_ctrl && !owner_ok && (i_hwdata[acq_pkg::CTRL_START]
		|| i_hwdata[acq_pkg::CTRL_STOP] || i_hwdata[acq_pkg::CTRL_RELEASE]
		|| (i_hwdata[acq_pkg::CTRL_CLAIM] && owned_r))) || (wr_rdidx && !rd_ok);

	// one connection owns the sequencer until it releases it
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			owned_r <= 1'b0;
			owner_r <= 8'h00;
		end else if (wr_ctrl && i_hwdata[acq_pkg::CTRL_CLAIM] && !owned_r) begin
			owned_r <= 1'b1;
			owner_r <= cmd_id;
		end else if (wr_ctrl && i_hwdata[acq_pkg::CTRL_RELEASE] && owner_ok && idle_like) begin
			owned_r <= 1'b0;
		end
	end

	// parameters are frozen while armed or running
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cfg_r <= acq_pkg::CFG_RST;
			period_r <= acq_pkg::PERIOD_RST;
			count_r <= acq_pkg::COUNT_RST;
			delay_r <= acq_pkg::DELAY_RST;
		end else if (wr_cfg) begin
			case (wr_addr_r)
				acq_pkg::REG_CONFIG: begin
					cfg_r <= i_hwdata & acq_pkg::CFG_WMASK;
				end
				acq_pkg::REG_PERIOD: begin
					period_r <= i_hwdata;
				end
				acq_pkg::REG_COUNT: begin
					count_r <= i_hwdata;
				end
				acq_pkg::REG_DELAY: begin
					delay_r <= i_hwdata;
				end
				default: begin
				end
			endcase
		end
	end

	assign min_per = nmode ? acq_pkg::NS_MIN_PER : acq_pkg::CONT_MIN_PER;
	assign period_eff = (period_r < min_per) ? min_per :
		((period_r > MAX_PERIOD) ? MAX_PERIOD : period_r);
	assign count_eff = (count_r == 32'h0) ? 32'h1 :
		((count_r > acq_pkg::MAX_COUNT) ? acq_pkg::MAX_COUNT : count_r);

	// internal pacing divider; external clock mode paces from the pin instead
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			div_cnt_r <= 32'h0;
		end else if (!st_run || is_ext || (div_cnt_r >= period_eff - 32'h1)) begin
			div_cnt_r <= 32'h0;
		end else begin
			div_cnt_r <= div_cnt_r + 32'h1;
		end
	end
	assign tick = st_run && (is_ext ? clk_rise : (div_cnt_r >= period_eff - 32'h1));

	assign wr_evt = st_run && conv_busy_r && i_conv_done;
	assign last_rec = wr_evt && nmode && !is_pre && (rec_cnt_r + 32'h1 == count_eff);
	assign pre_hit = st_run && is_pre && trig_fall;
	assign halt = stop_ok || last_rec || pre_hit;
	assign first_ch = next_ch(mask, 4'h0);
	assign nxt_ch = next_ch(mask, {1'b0, o_conv_chan} + 4'h1);

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r <= acq_pkg::ST_IDLE;
			dly_cnt_r <= 32'h0;
		end else if (stop_ok) begin
			state_r <= acq_pkg::ST_IDLE;
		end else begin
			case (state_r)
				acq_pkg::ST_IDLE, acq_pkg::ST_DONE: begin
					if (start_ok) begin
						// software, pre and external clock go straight to running
						state_r <= (is_post || is_dly) ? acq_pkg::ST_ARMED : acq_pkg::ST_RUN;
					end
				end
				acq_pkg::ST_ARMED: begin
					if (trig_fall && is_post) begin
						state_r <= acq_pkg::ST_RUN;
					end else if (trig_fall) begin
						state_r <= acq_pkg::ST_DELAY;
						dly_cnt_r <= delay_r;
					end
				end
				acq_pkg::ST_DELAY: begin
					if (dly_cnt_r == 32'h0) begin
						state_r <= acq_pkg::ST_RUN;
					end else begin
						dly_cnt_r <= dly_cnt_r - 32'h1;
					end
				end
				acq_pkg::ST_RUN: begin
					if (last_rec || pre_hit) begin
						state_r <= acq_pkg::ST_DONE;
					end
				end
				default: begin
					state_r <= acq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// scan walks the enabled channels once per tick; a tick mid-scan is an overrun
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			conv_busy_r <= 1'b0;
			o_conv_start <= 1'b0;
			o_conv_chan <= 3'h0;
		end else begin
			o_conv_start <= 1'b0;
			if (halt) begin
				conv_busy_r <= 1'b0;
			end else if (wr_evt) begin
				if (nxt_ch[3]) begin
					conv_busy_r <= 1'b0;
				end else begin
					o_conv_start <= 1'b1;
					o_conv_chan <= nxt_ch[2:0];
				end
			end else if (tick && !conv_busy_r) begin
				conv_busy_r <= 1'b1;
				o_conv_start <= 1'b1;
				o_conv_chan <= first_ch[2:0];
			end
		end
	end

	assign ring_top = nmode ? count_eff : {acq_pkg::PKT_WORDS[30:0], 1'b0};
	assign ptr_inc = {7'h00, wr_ptr_r} + 32'h1;

	// continuous mode uses a two-packet ring; pre-trigger a ring of count records
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wr_ptr_r <= 25'h0;
			wrapped_r <= 1'b0;
			rec_cnt_r <= 32'h0;
			o_mem_we <= 1'b0;
			o_mem_addr <= 25'h0;
			o_mem_wdata <= 32'h0;
			o_pkt_ready <= 1'b0;
			o_pkt_bank <= 1'b0;
		end else begin
			o_mem_we <= wr_evt;
			o_pkt_ready <= 1'b0;
			if (start_ok) begin
				wr_ptr_r <= 25'h0;
				wrapped_r <= 1'b0;
				rec_cnt_r <= 32'h0;
			end else if (wr_evt) begin
				o_mem_addr <= wr_ptr_r;
				o_mem_wdata <= {13'h0000, o_conv_chan, i_conv_data};
				rec_cnt_r <= rec_cnt_r + 32'h1;
				if ((!nmode || is_pre) && (ptr_inc >= ring_top)) begin
					wr_ptr_r <= 25'h0;
					wrapped_r <= is_pre;
				end else begin
					wr_ptr_r <= ptr_inc[24:0];
				end
				if (!nmode && ((ptr_inc == acq_pkg::PKT_WORDS) || (ptr_inc >= ring_top))) begin
					o_pkt_ready <= 1'b1;
					o_pkt_bank <= (ptr_inc > acq_pkg::PKT_WORDS);
				end
			end
		end
	end

	assign rec_avail = is_pre ? (wrapped_r ? count_eff : {7'h00, wr_ptr_r}) : rec_cnt_r;
	assign rd_ok = wr_rdidx && st_done && nmode && (i_hwdata < rec_avail);
	assign rd_sum = (is_pre && wrapped_r) ? ({7'h00, wr_ptr_r} + i_hwdata) : i_hwdata;
	assign rd_addr = (rd_sum >= count_eff) ? (rd_sum - count_eff) : rd_sum;

	// stored records leave only on request, oldest first
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_mem_re <= 1'b0;
			o_mem_raddr <= 25'h0;
			rd_pend_r <= 1'b0;
			rd_valid_r <= 1'b0;
			rd_idx_r <= 32'h0;
			rd_data_r <= 32'h0;
		end else begin
			o_mem_re <= rd_ok;
			rd_pend_r <= o_mem_re;
			if (rd_ok) begin
				o_mem_raddr <= rd_addr[24:0];
				rd_idx_r <= i_hwdata;
				rd_valid_r <= 1'b0;
			end else if (rd_pend_r) begin
				rd_data_r <= i_mem_rdata;
				rd_valid_r <= 1'b1;
			end
		end
	end

	// sticky flags, write one to clear; a new event wins over the clear
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			refused_r <= 1'b0;
			cfg_err_r <= 1'b0;
			overrun_r <= 1'b0;
		end else begin
			refused_r <= refuse || (refused_r && !(wr_status && i_hwdata[acq_pkg::STS_REFUSED]));
			cfg_err_r <= start_bad || (cfg_err_r && !(wr_status && i_hwdata[acq_pkg::STS_CFG_ERR]));
			overrun_r <= (tick && conv_busy_r && !halt)
				|| (overrun_r && !(wr_status && i_hwdata[acq_pkg::STS_OVERRUN]));
		end
	end

	always_comb begin
		status_w = 32'h0;
		status_w[4:0] = state_r;
		status_w[acq_pkg::STS_REFUSED] = refused_r;
		status_w[acq_pkg::STS_CFG_ERR] = cfg_err_r;
		status_w[acq_pkg::STS_OVERRUN] = overrun_r;
		status_w[acq_pkg::STS_OWNED] = owned_r;
		status_w[acq_pkg::STS_RD_VALID] = rd_valid_r;
		status_w[acq_pkg::STS_WRAPPED] = wrapped_r;
		status_w[acq_pkg::STS_OWNER_LSB +: 8] = owner_r;
	end

	// read data is registered in the address phase so it stands through the data phase
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_hrdata <= 32'h0;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
				case (i_haddr[7:0])
					acq_pkg::REG_CONFIG: o_hrdata <= cfg_r;
					acq_pkg::REG_PERIOD: o_hrdata <= period_r;
					acq_pkg::REG_COUNT: o_hrdata <= count_r;
					acq_pkg::REG_DELAY: o_hrdata <= delay_r;
					acq_pkg::REG_STATUS: o_hrdata <= status_w;
					acq_pkg::REG_RECORDS: o_hrdata <= rec_avail;
					acq_pkg::REG_RD_INDEX: o_hrdata <= rd_idx_r;
					acq_pkg::REG_RD_DATA: o_hrdata <= rd_data_r;
					default: o_hrdata <= 32'h0;
				endcase
			end
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_post_fire;
		st_armed && is_post && trig_fall && !stop_ok;
	endsequence
	sequence s_dly_fire;
		st_armed && is_dly && trig_fall && !stop_ok;
	endsequence
	property p_post_run;
		s_post_fire |=> st_run;
	endproperty
	a_post_run: assert property (p_post_run) else $error("post trigger did not start run");
	property p_dly_wait;
		s_dly_fire |=> st_dly && (dly_cnt_r == $past(delay_r));
	endproperty
	a_dly_wait: assert property (p_dly_wait) else $error("delay not loaded on trigger");
	property p_dly_end;
		(st_dly && dly_cnt_r == 32'h0 && !stop_ok) |=> st_run;
	endproperty
	a_dly_end: assert property (p_dly_end) else $error("delay expiry did not start run");
	property p_stop_idle;
		stop_ok |=> st_idle && !conv_busy_r;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to idle");
	property p_start_busy;
		(start_req && st_run && !nmode && !stop_ok) |=> st_run && (rec_cnt_r >= $past(rec_cnt_r));
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start disturbed a run");
	property p_last_done;
		(last_rec && !stop_ok) |=> st_done && !conv_busy_r ##1 !o_conv_start;
	endproperty
	a_last_done: assert property (p_last_done) else $error("count reached but still sampling");
	property p_pre_halt;
		(pre_hit && !stop_ok) |=> st_done && !o_conv_start;
	endproperty
	a_pre_halt: assert property (p_pre_halt) else $error("pre trigger did not halt");
	property p_bad_combo;
		start_bad |=> cfg_err_r && (st_idle || st_done);
	endproperty
	a_bad_combo: assert property (p_bad_combo) else $error("illegal mode pair accepted");
	property p_ok_combo;
		start_ok |-> !(cnt_sel && !is_sw) && !(is_ext && nmode);
	endproperty
	a_ok_combo: assert property (p_ok_combo) else $error("blocked trigger mode started");
	property p_refuse;
		(start_req && !owner_ok) |=> refused_r && !$changed(state_r);
	endproperty
	a_refuse: assert property (p_refuse) else $error("foreign start not refused");
	property p_chan_sel;
		o_conv_start |-> mask[o_conv_chan];
	endproperty
	a_chan_sel: assert property (p_chan_sel) else $error("disabled channel converted");
	property p_ext_tick;
		(st_run && is_ext && !conv_busy_r && clk_rise && !halt) |=> o_conv_start && conv_busy_r;
	endproperty
	a_ext_tick: assert property (p_ext_tick) else $error("external clock missed a scan");
	property p_pace;
		(tick && !is_ext) |-> (period_eff >= min_per) && (period_eff <= MAX_PERIOD);
	endproperty
	a_pace: assert property (p_pace) else $error("sample period out of range");
	property p_pkt;
		(wr_evt && !nmode && ptr_inc == acq_pkg::PKT_WORDS) |=> o_pkt_ready && !o_pkt_bank;
	endproperty
	a_pkt: assert property (p_pkt) else $error("full packet not announced");
endmodule : adc_acquisition_sequencer
`default_nettype wire

//--- adc_conv_model.sv
// converter and sample memory model for the far side of the sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_conv_model (
	input wire logic i_sys_clk,
	input wire logic i_conv_start,
	input wire logic [2:0] i_conv_chan,
	output logic o_conv_done,
	output logic [15:0] o_conv_data,
	input wire logic i_mem_we,
	input wire logic [24:0] i_mem_addr,
	input wire logic [31:0] i_mem_wdata,
	input wire logic i_mem_re,
	input wire logic [24:0] i_mem_raddr,
	output logic [31:0] o_mem_rdata
);
	logic [31:0] mem [0:1023];
	logic [3:0] busy_r = 4'h0;
	initial begin
		o_conv_done = 1'b0;
		o_conv_data = 16'h0;
		o_mem_rdata = 32'h0;
	end
	// data is only held in the done cycle, inverted otherwise so stale reuse shows
	always @(posedge i_sys_clk) begin
		busy_r <= {busy_r[2:0], i_conv_start};
		o_conv_done <= busy_r[3];
		o_conv_data <= busy_r[3] ? {13'h1400, i_conv_chan} : ~o_conv_data;
		if (i_mem_we)
			mem[i_mem_addr[9:0]] <= i_mem_wdata;
		o_mem_rdata <= i_mem_re ? mem[i_mem_raddr[9:0]] : ~o_mem_rdata;
	end
endmodule : adc_conv_model
`default_nettype wire

//--- adc_acquisition_sequencer_tb.sv
// self-checking bench for the acquisition sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_acquisition_sequencer_tb;
	logic clk, rst, hsel, hwrite, trig, eclk, cdone, hready, cstart, mwe, mre;
	logic pkt, pbank, hresp, pbank_seen;
	int pkts = 0;
	logic [1:0] htrans;
	logic [2:0] hsize, cchan;
	logic [31:0] haddr, hwdata, hrdata, mrdata, rd, mwd;
	logic [15:0] cdata;
	logic [24:0] maddr, mraddr;
	logic [31:0] bad [3] = '{32'h0000_1101, 32'h0001_3104, 32'h0000_2001};
	logic [2:0] tm [3] = '{3'h3, 3'h4, 3'h2};
	int err_count = 0;
	int num_checks = 0;
	int nconv = 0;
	int n0;
	adc_acquisition_sequencer #(.MAX_PERIOD(32'd2000)) dut_u (.i_sys_clk(clk), .i_sys_rst(rst),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_ext_trig(trig), .i_ext_clk(eclk), .o_conv_start(cstart), .o_conv_chan(cchan),
		.i_conv_done(cdone), .i_conv_data(cdata), .o_mem_we(mwe), .o_mem_addr(maddr),
		.o_mem_wdata(mwd), .o_mem_re(mre), .o_mem_raddr(mraddr), .i_mem_rdata(mrdata),
		.o_pkt_ready(pkt), .o_pkt_bank(pbank));
	adc_conv_model model_u (.i_sys_clk(clk), .i_conv_start(cstart), .i_conv_chan(cchan),
		.o_conv_done(cdone), .o_conv_data(cdata), .i_mem_we(mwe), .i_mem_addr(maddr),
		.i_mem_wdata(mwd), .i_mem_re(mre), .i_mem_raddr(mraddr), .o_mem_rdata(mrdata));
	always @(posedge clk) begin
		if (cstart === 1'b1)
			nconv <= nconv + 1;
	end
	always @(posedge clk) begin
		if (pkt === 1'b1) begin
			pkts <= pkts + 1;
			pbank_seen <= pbank;
		end
	end
	task automatic conclude();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// one single transfer; the leading edge leaves an idle cycle after any write
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		xfer(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask : rdchk
	task automatic wait_st(input logic [4:0] s);
		int n;
		n = 0;
		do begin
			xfer(1'b0, 8'h14, 32'h0);
			n++;
		end while (rd[4:0] !== s && n < 400);
		chk({27'h0, rd[4:0]}, {27'h0, s});
	endtask : wait_st
	task automatic pin_pulse(input logic clk_pin);
		@(posedge clk);
		if (clk_pin)
			eclk <= 1'b1;
		else
			trig <= 1'b0;
		repeat (60) @(posedge clk);
		eclk <= 1'b0;
		trig <= 1'b1;
		repeat (300) @(posedge clk);
	endtask : pin_pulse
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		trig = 1'b1;
		eclk = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdchk(8'h14, 32'h0000_0001, 32'hffff_ffff);
		rdchk(8'h04, 32'h0000_00ff, 32'hffff_ffff);
		rdchk(8'h0c, 32'h0000_03e8, 32'hffff_ffff);
		wr(8'h00, 32'h0000_0504);
		wr(8'h00, 32'h0000_0901);
		rdchk(8'h14, 32'h0005_0121, 32'hffff_ffff);
		wr(8'h14, 32'h0000_0020);
		// three illegal mode pairings must be turned away: ext clock in n-sample, counter input with post, pre in continuous
		foreach (bad[i]) begin
			wr(8'h04, bad[i]);
			wr(8'h00, 32'h0000_0501);
			rdchk(8'h14, 32'h0005_0141, 32'hffff_ffff);
			wr(8'h14, 32'h0000_0040);
		end
		wr(8'h04, 32'h0000_0104);
		wr(8'h08, 32'h0000_00c8);
		wr(8'h0c, 32'h0000_0003);
		wr(8'h00, 32'h0000_0501);
		wr(8'h00, 32'h0000_0501);
		rdchk(8'h14, 32'h0000_0008, 32'h0000_00ff);
		wait_st(5'h10);
		rdchk(8'h18, 32'h0000_0003, 32'hffff_ffff);
		wr(8'h1c, 32'h0000_0001);
		repeat (4) @(posedge clk);
		rdchk(8'h20, 32'h0002_a002, 32'hffff_ffff);
		wr(8'h10, 32'h0000_0200);
		foreach (tm[i]) begin
			wr(8'h04, {17'h0, tm[i], 12'h104});
			wr(8'h00, 32'h0000_0501);
			rdchk(8'h14, tm[i] == 3'h2 ? 32'h8 : 32'h2, 32'h1f);
			pin_pulse(1'b0);
			rdchk(8'h14, tm[i] == 3'h4 ? 32'h4 : tm[i] == 3'h3 ? 32'h8 : 32'h10, 32'h1f);
			wait_st(5'h10);
		end
		wr(8'h04, 32'h0000_0001);
		wr(8'h08, 32'h0000_0005);
		wr(8'h00, 32'h0000_0501);
		wr(8'h00, 32'h0000_0501);
		n0 = nconv;
		repeat (3000) @(posedge clk);
		chk({31'h0, nconv - n0 >= 2 && nconv - n0 <= 3}, 32'h1);
		rdchk(8'h14, 32'h0000_0008, 32'h1f);
		wr(8'h00, 32'h0000_0502);
		rdchk(8'h14, 32'h0000_0001, 32'h1f);
		wr(8'h04, 32'h0000_1001);
		wr(8'h00, 32'h0000_0501);
		n0 = nconv;
		repeat (200) @(posedge clk);
		chk(32'(nconv - n0), 32'h0);
		repeat (4) pin_pulse(1'b1);
		chk(32'(nconv - n0), 32'h4);
		wr(8'h00, 32'h0000_0502);
		pin_pulse(1'b1);
		chk(32'(nconv - n0), 32'h4);
		// 64 external-clock scans of all eight channels fill exactly one packet
		wr(8'h04, 32'h0000_10ff);
		wr(8'h00, 32'h0000_0501);
		repeat (64) begin
			@(posedge clk);
			eclk <= 1'b1;
			repeat (40) @(posedge clk);
			eclk <= 1'b0;
			repeat (40) @(posedge clk);
		end
		repeat (20) @(posedge clk);
		chk(32'(pkts), 32'h1);
		chk({31'h0, pbank_seen}, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		conclude();
	end
endmodule : adc_acquisition_sequencer_tb
`default_nettype wire
